// [logic/rmc_ref_core.sv]
// top: two acquisition loops, source selector and core pll mode control
`timescale 1ns/10ps
module rmc_ref_core
  import rmc_pkg::*;
#(
  parameter longint unsigned GATE = GATE_TICKS,
  parameter longint unsigned LOSS = LOSS_CYC
) (
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  input  wire logic              first_reference_in_i,
  input  wire logic              second_reference_in_i,
  input  wire logic              master_osc_in_i,
  input  wire logic              ref_sel_i,
  input  wire logic              force_holdover_i,
  input  wire logic [CAL_W-1:0]  mclk_cal_i,
  output rmc_acq_status_s        first_status_o,
  output rmc_acq_status_s        second_status_o,
  output logic                   acceptance_range_flag_o,
  output logic                   second_acceptance_range_flag_o,
  output rmc_core_mode_e         core_mode_o,
  output logic [PH_W-1:0]        core_phase_word_o,
  output logic                   core_phase_vld_o,
  output logic [CNT_W-1:0]       core_freq_word_o,
  output logic [PH_W-1:0]        core_accum_o
);

  // ***************************************************************
  // master oscillator sampling and time base
  // ***************************************************************
  logic [2:0]        mosc_sync_q;
  logic              mosc_lvl_q;
  logic              mosc_tick;
  logic [PH_W-1:0]   time_q;

  // the 20 MHz oscillator is asynchronous: three stages, agreement of two and three;
  // the price is two to three cycles of tick latency, paid alike by the references
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mosc_sync_q <= 3'h0;
      mosc_lvl_q  <= 1'b0;
    end else begin
      mosc_sync_q <= {mosc_sync_q[1:0], master_osc_in_i};
      if (mosc_sync_q[1] == mosc_sync_q[2]) begin
        mosc_lvl_q <= mosc_sync_q[2];
      end
    end
  end

  // rising edge of the sampled oscillator marks one tick
  assign mosc_tick = (mosc_sync_q[1] == mosc_sync_q[2]) && mosc_sync_q[2] && !mosc_lvl_q;

  // time stamps count oscillator ticks, so phase words share the core time base;
  // they wrap after 2^32 ticks, harmless since the core only takes differences
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      time_q <= '0;
    end else if (mosc_tick) begin
      time_q <= time_q + 1'b1;
    end
  end

  // ***************************************************************
  // two independent acquisition loops
  // ***************************************************************
  // per-loop status, phase words and gate counts
  rmc_acq_status_s   st1, st2;
  logic [PH_W-1:0]   ph1, ph2;
  logic              pv1, pv2;
  logic [CNT_W-1:0]  cnt1, cnt2;

  // identical instances: same thresholds, own flags for each reference;
  // both run all the time, so a standby reference is graded before it is chosen
  rmc_acq_mon #(.GATE(GATE), .LOSS(LOSS)) u_first (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .ref_in_i    (first_reference_in_i),
    .mosc_tick_i (mosc_tick),
    .time_i      (time_q),
    .status_o    (st1),
    .phase_o     (ph1),
    .phase_vld_o (pv1),
    .count_o     (cnt1)
  );

  rmc_acq_mon #(.GATE(GATE), .LOSS(LOSS)) u_second (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .ref_in_i    (second_reference_in_i),
    .mosc_tick_i (mosc_tick),
    .time_i      (time_q),
    .status_o    (st2),
    .phase_o     (ph2),
    .phase_vld_o (pv2),
    .count_o     (cnt2)
  );

  // status and acceptance pins straight from flops;
  // they lag the loops by one cycle, as does the mode, so both change in the same cycle
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      first_status_o                 <= STATUS_RST;
      second_status_o                <= STATUS_RST;
      acceptance_range_flag_o        <= 1'b1;
      second_acceptance_range_flag_o <= 1'b1;
    end else begin
      first_status_o                 <= st1;
      second_status_o                <= st2;
      acceptance_range_flag_o        <= st1.acceptance_range_flag;
      second_acceptance_range_flag_o <= st2.acceptance_range_flag;
    end
  end

  // ***************************************************************
  // selector: binary phase words toward the core phase detector
  // ***************************************************************
  // selected loop's signals, all from the same ref_sel_i level
  logic              sel_hold;
  logic [CNT_W-1:0]  sel_cnt;
  logic              sel_pv;
  logic [PH_W-1:0]   sel_ph;

  // ref_sel_i low picks the first loop, high the second;
  // the switch is not hitless: a word from the new loop may directly follow
  // one from the old loop, so the core sees a phase step at the change
  assign sel_hold = ref_sel_i ? st2.holdover : st1.holdover;
  assign sel_cnt  = ref_sel_i ? cnt2 : cnt1;
  assign sel_pv   = ref_sel_i ? pv2 : pv1;
  assign sel_ph   = ref_sel_i ? ph2 : ph1;

  // phase words registered on their valid pulse, held between pulses
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      core_phase_word_o <= '0;
      core_phase_vld_o  <= 1'b0;
    end else begin
      core_phase_vld_o <= sel_pv;
      if (sel_pv) begin
        core_phase_word_o <= sel_ph;
      end
    end
  end

  // ***************************************************************
  // core pll mode control
  // ***************************************************************
  // next mode, plus the stored word for holdover and whether it is real
  rmc_core_mode_e    mode_d;
  logic              seen_valid_q;
  logic [CNT_W-1:0]  held_word_q;

  // free-run until a good reference has been seen; after that a bad one
  // means holdover, since stored data exists to hold on to;
  // force_holdover_i comes from logic on this clock, so it needs no sync
  always_comb begin
    mode_d = CORE_FREE;
    case (core_mode_o)
      CORE_FREE: begin
        if (!sel_hold && !force_holdover_i) begin
          mode_d = CORE_NORMAL;
        end else begin
          mode_d = CORE_FREE;
        end
      end
      CORE_NORMAL, CORE_HOLD: begin
        if (sel_hold || force_holdover_i) begin
          mode_d = CORE_HOLD;
        end else begin
          mode_d = CORE_NORMAL;
        end
      end
      default: mode_d = CORE_FREE;
    endcase
  end

  // registered mode; the fourth code of the enum is never entered
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      core_mode_o <= CORE_FREE;
    end else begin
      core_mode_o <= mode_d;
    end
  end

  // holdover memory: last word taken while locked to a healthy loop;
  // the word lags the mode by a cycle, so a loop that fails in its second
  // normal cycle leaves the free-run word stored
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      seen_valid_q <= 1'b0;
      held_word_q  <= FREE_NOM_WORD;
    end else if (core_mode_o == CORE_NORMAL && !sel_hold) begin
      seen_valid_q <= 1'b1;
      held_word_q  <= core_freq_word_o;
    end
  end

  // frequency word per mode; free-run adds the signed oscillator correction;
  // normal mode takes the gate count unfiltered, so it steps once per gate
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      core_freq_word_o <= FREE_NOM_WORD;
    end else begin
      case (core_mode_o)
        CORE_FREE:   core_freq_word_o <= FREE_NOM_WORD
                                         + CNT_W'(signed'(mclk_cal_i));
        CORE_NORMAL: core_freq_word_o <= sel_cnt;
        CORE_HOLD:   core_freq_word_o <= seen_valid_q ? held_word_q
                                                      : FREE_NOM_WORD;
        default:     core_freq_word_o <= FREE_NOM_WORD;
      endcase
    end
  end

  // phase accumulator stepped by the oscillator, the core's only time base;
  // it wraps freely, only its rate matters to the clock synthesis after it
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      core_accum_o <= '0;
    end else if (mosc_tick) begin
      core_accum_o <= core_accum_o + PH_W'(core_freq_word_o);
    end
  end

endmodule

// [logic/rmc_pkg.sv]
// constants, types and timing for the reference monitor and core pll mode block
//
// Summary of operation
// - each loop tracks its reference alone; falling edges, rising edge at 19.44 MHz
// - each loop reports a two-bit detected frequency code in its status
// - drift beyond 30000 ppm or loss puts the loop in holdover, flag set
// - holdover of the loop feeding the core forces core automatic holdover once the core has left free-run
// - drift beyond 104 ppm sets the capture limit flag
// - drift beyond 12 ppm drives acceptance range status bit and pin high
// - second loop applies the same three thresholds with its own flags
// - selector passes chosen loop phase data to the core as binary words
// - core has exactly three modes: free-run, normal, holdover
// - in free-run the core runs from the 20 MHz master oscillator
// - a writable calibration value corrects master oscillator error in free-run
// - in normal mode the core follows the selected loop phase data
// - in holdover the core uses stored frequency data, no live reference
// - out of free-run the core holds over when its loop holds over; control input may force it
package rmc_pkg;

  // ***************************************************************
  // clocks and timing
  // ***************************************************************
  localparam longint unsigned SYS_CLK_HZ    = 100_000_000;
  localparam longint unsigned MOSC_HZ       = 20_000_000;
  localparam longint unsigned GATE_TIME_MS  = 1000;          // measuring gate length
  localparam longint unsigned GATE_TICKS    = MOSC_HZ * GATE_TIME_MS / 1000;
  localparam longint unsigned LOSS_TIME_US  = 250;           // two 8 kHz periods
  localparam longint unsigned LOSS_CYC      = (LOSS_TIME_US * SYS_CLK_HZ + 999_999)
                                              / 1_000_000;

  // ***************************************************************
  // quality thresholds in ppm
  // ***************************************************************
  localparam longint unsigned HOLD_PPM      = 30000;
  localparam longint unsigned LIMIT_PPM     = 104;
  localparam longint unsigned ACCEPT_PPM    = 12;
  localparam longint unsigned PPM_SCALE     = 1_000_000;

  // ***************************************************************
  // widths, codes and reset values
  // ***************************************************************
  localparam int              CNT_W         = 32;
  localparam int              CAL_W         = 16;
  localparam int              PH_W          = 32;
  localparam logic [1:0]      FREQ_8K       = 2'h0;
  localparam logic [1:0]      FREQ_1M544    = 2'h1;
  localparam logic [1:0]      FREQ_2M048    = 2'h2;
  localparam logic [1:0]      FREQ_19M44    = 2'h3;
  localparam longint unsigned NOM_8K_HZ     = 8000;
  localparam longint unsigned NOM_1M544_HZ  = 1_544_000;
  localparam longint unsigned NOM_2M048_HZ  = 2_048_000;
  localparam longint unsigned NOM_19M44_HZ  = 19_440_000;
  localparam logic [CNT_W-1:0] FREE_NOM_WORD = 32'h0001_0000; // unit step per tick

  typedef struct packed {
    logic ref_freq_code_hi;
    logic ref_freq_code_lo;
    logic holdover;
    logic capture_limit_flag;
    logic acceptance_range_flag;
  } rmc_acq_status_s;

  localparam rmc_acq_status_s STATUS_RST = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};

  typedef enum logic [1:0] {
    CORE_FREE,
    CORE_NORMAL,
    CORE_HOLD
  } rmc_core_mode_e;

  // nominal edge count in one gate for a frequency code
  function automatic longint unsigned rmc_nom_count(input logic [1:0] code,
                                                    input longint unsigned gate);
    longint unsigned hz;
    case (code)
      FREQ_8K:    hz = NOM_8K_HZ;
      FREQ_1M544: hz = NOM_1M544_HZ;
      FREQ_2M048: hz = NOM_2M048_HZ;
      default:    hz = NOM_19M44_HZ;
    endcase
    return hz * gate / MOSC_HZ;
  endfunction

  // true when a count lies further than ppm from its nominal
  function automatic logic rmc_beyond(input longint unsigned cnt,
                                      input longint unsigned nom,
                                      input longint unsigned ppm);
    longint unsigned dev;
    dev = (cnt > nom) ? cnt - nom : nom - cnt;
    return (dev * PPM_SCALE) > (ppm * nom);
  endfunction

endpackage

// [logic/rmc_acq_mon.sv]
// acquisition loop: reference sampling, frequency detection and quality grading
`timescale 1ns/10ps
module rmc_acq_mon
  import rmc_pkg::*;
#(
  parameter longint unsigned GATE = GATE_TICKS,
  parameter longint unsigned LOSS = LOSS_CYC
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  input  wire logic             ref_in_i,
  input  wire logic             mosc_tick_i,
  input  wire logic [PH_W-1:0]  time_i,
  output rmc_acq_status_s       status_o,
  output logic [PH_W-1:0]       phase_o,
  output logic                  phase_vld_o,
  output logic [CNT_W-1:0]      count_o
);

  // ***************************************************************
  // reference sampling
  // ***************************************************************
  logic [2:0]        sync_q;
  logic              lvl_q;
  logic              rise, fall, act_edge;
  logic [CNT_W-1:0]  gate_q, edges_q, loss_q;
  logic [1:0]        code_q;
  logic [1:0]        found;
  logic              any_ok;

  // three stages; a change counts only once stages two and three agree;
  // reset to the pulled-up idle level, so a quiet pin shows no edge after reset
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sync_q <= 3'h7;
      lvl_q  <= 1'b1;
    end else begin
      sync_q <= {sync_q[1:0], ref_in_i};
      if (sync_q[1] == sync_q[2]) begin
        lvl_q <= sync_q[2];
      end
    end
  end

  assign rise     = (sync_q[1] == sync_q[2]) && sync_q[2] && !lvl_q;
  assign fall     = (sync_q[1] == sync_q[2]) && !sync_q[2] && lvl_q;
  assign act_edge = (code_q == FREQ_19M44) ? rise : fall;

  // ***************************************************************
  // phase words: time stamp of each active edge
  // ***************************************************************
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      phase_o     <= '0;
      phase_vld_o <= 1'b0;
    end else begin
      phase_vld_o <= act_edge;
      if (act_edge) begin
        phase_o <= time_i;
      end
    end
  end

  // ***************************************************************
  // classification at the end of each gate
  // ***************************************************************
  always_comb begin
    found  = FREQ_8K;
    any_ok = 1'b0;
    for (int c = 0; c < 4; c++) begin
      if (!rmc_beyond(longint'(edges_q), rmc_nom_count(2'(c), GATE), HOLD_PPM)) begin
        found  = 2'(c);
        any_ok = 1'b1;
      end
    end
  end

  // gate of master oscillator ticks; edge count restarts with each gate
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      gate_q  <= '0;
      edges_q <= '0;
      count_o <= '0;
    end else if (mosc_tick_i && gate_q == CNT_W'(GATE - 1)) begin
      gate_q  <= '0;
      edges_q <= CNT_W'(act_edge);
      count_o <= edges_q;
    end else begin
      if (mosc_tick_i) begin
        gate_q <= gate_q + 1'b1;
      end
      if (act_edge) begin
        edges_q <= edges_q + 1'b1;
      end
    end
  end

  // loss detector: no edge of either kind for the loss time
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      loss_q <= '0;
    end else if (rise || fall) begin
      loss_q <= '0;
    end else if (loss_q != CNT_W'(LOSS)) begin
      loss_q <= loss_q + 1'b1;
    end
  end

  // flags change only at gate ends, so each holds until a clean gate clears it;
  // a lost reference raises all of them at once without waiting for the gate
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      code_q   <= FREQ_8K;
      status_o <= STATUS_RST;
    end else if (loss_q == CNT_W'(LOSS)) begin
      status_o.holdover              <= 1'b1;
      status_o.capture_limit_flag    <= 1'b1;
      status_o.acceptance_range_flag <= 1'b1;
    end else if (mosc_tick_i && gate_q == CNT_W'(GATE - 1)) begin
      if (any_ok) begin
        code_q                         <= found;
        status_o.ref_freq_code_hi      <= found[1];
        status_o.ref_freq_code_lo      <= found[0];
        status_o.holdover              <= 1'b0;
        status_o.capture_limit_flag    <=
          rmc_beyond(longint'(edges_q), rmc_nom_count(found, GATE), LIMIT_PPM);
        status_o.acceptance_range_flag <=
          rmc_beyond(longint'(edges_q), rmc_nom_count(found, GATE), ACCEPT_PPM);
      end else begin
        status_o.holdover              <= 1'b1;
        status_o.capture_limit_flag    <= 1'b1;
        status_o.acceptance_range_flag <= 1'b1;
      end
    end
  end

endmodule

// [verification/rmc_ref_core_monitor.sv]
// concurrent checks on the ports of the reference monitor and core pll mode block
`timescale 1ns/10ps
module rmc_ref_core_monitor
  import rmc_pkg::*;
#(
  parameter longint unsigned GATE = GATE_TICKS,
  parameter longint unsigned LOSS = LOSS_CYC
) (
  input wire logic             clk_sys_i,
  input wire logic             rst_i,
  input wire logic             first_reference_in_i,
  input wire logic             second_reference_in_i,
  input wire logic             master_osc_in_i,
  input wire logic             ref_sel_i,
  input wire logic             force_holdover_i,
  input wire logic [CAL_W-1:0] mclk_cal_i,
  input wire rmc_acq_status_s  first_status_o,
  input wire rmc_acq_status_s  second_status_o,
  input wire logic             acceptance_range_flag_o,
  input wire logic             second_acceptance_range_flag_o,
  input wire rmc_core_mode_e   core_mode_o,
  input wire logic [PH_W-1:0]  core_phase_word_o,
  input wire logic             core_phase_vld_o,
  input wire logic [CNT_W-1:0] core_freq_word_o,
  input wire logic [PH_W-1:0]  core_accum_o
);
  // ****************************************
  // mode control
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  a_force_hold: assert property (
    force_holdover_i && core_mode_o != CORE_FREE |=> core_mode_o == CORE_HOLD)
    else $error("core did not hold over on force");
  // mode lags the selector by one cycle, as the status port does
  a_loop_hold: assert property (
    ($past(ref_sel_i) ? second_status_o.holdover : first_status_o.holdover)
    |-> core_mode_o != CORE_NORMAL)
    else $error("core normal while its loop holds over");
  a_normal_cause: assert property (
    core_mode_o == CORE_NORMAL |-> !$past(force_holdover_i))
    else $error("core normal while forced");
  a_never_free: assert property (
    core_mode_o != CORE_FREE |=> core_mode_o inside {CORE_NORMAL, CORE_HOLD})
    else $error("core mode returned to free run or left the three modes");
  a_free_word: assert property (
    (core_mode_o == CORE_FREE && $stable(mclk_cal_i)) [*4]
    |-> core_freq_word_o == FREE_NOM_WORD + {{16{mclk_cal_i[15]}}, mclk_cal_i})
    else $error("free run word ignores calibration");
  a_hold_word: assert property (
    (core_mode_o == CORE_HOLD) [*2] |=> $stable(core_freq_word_o))
    else $error("held frequency word moved");
  // ****************************************
  // grading and phase words
  // ****************************************
  a_pin_match: assert property (
    acceptance_range_flag_o == first_status_o.acceptance_range_flag &&
    second_acceptance_range_flag_o == second_status_o.acceptance_range_flag)
    else $error("acceptance pin differs from status bit");
  // a wider tolerance broken implies every narrower one broken
  a_flag_nest: assert property (
    (!first_status_o.holdover || first_status_o.capture_limit_flag) &&
    (!first_status_o.capture_limit_flag || first_status_o.acceptance_range_flag) &&
    (!second_status_o.holdover || second_status_o.capture_limit_flag) &&
    (!second_status_o.capture_limit_flag || second_status_o.acceptance_range_flag))
    else $error("quality flags out of order");
  a_vld_pulse: assert property (
    core_phase_vld_o |=> !core_phase_vld_o)
    else $error("phase valid longer than one cycle");
  a_word_vld: assert property (
    $changed(core_phase_word_o) |-> core_phase_vld_o)
    else $error("phase word moved without valid");
  c_enter_hold: cover property (core_mode_o == CORE_NORMAL ##1 core_mode_o == CORE_HOLD);
  c_loss: cover property ($rose(first_status_o.holdover));
  c_second_vld: cover property (core_phase_vld_o && ref_sel_i);
endmodule

bind rmc_ref_core rmc_ref_core_monitor #(.GATE(GATE), .LOSS(LOSS)) mon_u (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .first_reference_in_i(first_reference_in_i),
  .second_reference_in_i(second_reference_in_i), .master_osc_in_i(master_osc_in_i),
  .ref_sel_i(ref_sel_i), .force_holdover_i(force_holdover_i), .mclk_cal_i(mclk_cal_i),
  .first_status_o(first_status_o), .second_status_o(second_status_o),
  .acceptance_range_flag_o(acceptance_range_flag_o),
  .second_acceptance_range_flag_o(second_acceptance_range_flag_o),
  .core_mode_o(core_mode_o), .core_phase_word_o(core_phase_word_o),
  .core_phase_vld_o(core_phase_vld_o), .core_freq_word_o(core_freq_word_o),
  .core_accum_o(core_accum_o)
);

// [verification/rmc_ref_src.sv]
// model of the two network reference sources and the 20 MHz master oscillator
`timescale 1ns/10ps
module rmc_ref_src (
  input  wire logic [11:0] div_a_i,
  input  wire logic [11:0] div_b_i,
  output logic             osc_o,
  output logic             ref_a_o,
  output logic             ref_b_o
);
  logic [11:0] cnt_a = 12'h000;
  logic [11:0] cnt_b = 12'h000;
  // oscillator phase unrelated to the system clock
  initial begin
    osc_o = 1'b0;
    #3;
    forever #25 osc_o = ~osc_o;
  end
  // references derived from oscillator ticks so edges per gate are exact
  always @(posedge osc_o) begin
    cnt_a <= (cnt_a >= div_a_i - 12'd1) ? 12'd0 : cnt_a + 12'd1;
    cnt_b <= (cnt_b >= div_b_i - 12'd1) ? 12'd0 : cnt_b + 12'd1;
  end
  // a stopped source leaves its pin at the pull-up level
  function automatic logic lvl(input logic [11:0] d, input logic [11:0] c, input logic o);
    return (d == 12'd0) ? 1'b1 : (d == 12'd1) ? o : (c >= (d >> 1));
  endfunction
  assign ref_a_o = lvl(div_a_i, cnt_a, osc_o);
  assign ref_b_o = lvl(div_b_i, cnt_b, osc_o);
endmodule

// [verification/rmc_ref_core_tb.sv]
// self-checking bench for the reference monitor and core pll mode block
`timescale 1ns/10ps
module rmc_ref_core_tb;
  import rmc_pkg::*;
  localparam longint unsigned GATE = 2500;  // 12500 sys cycles a gate
  localparam longint unsigned LOSS = 15000; // above one 8 kHz period
  localparam int              G2   = 25020; // two gates plus settling
  logic             clk_sys_i, rst_i, ref_sel_i, force_holdover_i;
  logic [CAL_W-1:0] mclk_cal_i;
  logic [11:0]      div_a, div_b;
  logic             ref_a, ref_b, osc, acc_a, acc_b, vld;
  rmc_acq_status_s  st_a, st_b;
  rmc_core_mode_e   mode;
  logic [PH_W-1:0]  ph, accu;
  logic [CNT_W-1:0] fw, w0, w1;
  int               err_count = 0, checks = 0, cyc = 0, n;

  rmc_ref_src src_u (.div_a_i(div_a), .div_b_i(div_b), .osc_o(osc), .ref_a_o(ref_a),
                     .ref_b_o(ref_b));
  rmc_ref_core #(.GATE(GATE), .LOSS(LOSS)) dut_u (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .first_reference_in_i(ref_a),
    .second_reference_in_i(ref_b), .master_osc_in_i(osc), .ref_sel_i(ref_sel_i),
    .force_holdover_i(force_holdover_i), .mclk_cal_i(mclk_cal_i), .first_status_o(st_a),
    .second_status_o(st_b), .acceptance_range_flag_o(acc_a),
    .second_acceptance_range_flag_o(acc_b), .core_mode_o(mode), .core_phase_word_o(ph),
    .core_phase_vld_o(vld), .core_freq_word_o(fw), .core_accum_o(accu));

  // ****************************************
  // clock, timeout and helpers
  // ****************************************
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // a hung run still reaches the verdict
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 99000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys_i);
  endtask
  task automatic chk_word(input logic [31:0] act, input logic [31:0] exp);
    checks++;
    if (act !== exp) begin
      err_count++;
      $display("wrong value at %0t: word %h, expected %h", $time, act, exp);
    end
  endtask
  task automatic chk_stat(input rmc_acq_status_s act, input logic [4:0] exp,
                          input logic [4:0] m);
    checks++;
    if ((act & m) !== (exp & m)) begin
      err_count++;
      $display("wrong value at %0t: status %b, expected %b", $time, act, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst_i = 1'b1;
    ref_sel_i = 1'b0;
    force_holdover_i = 1'b0;
    mclk_cal_i = 16'hfff0;
    div_a = 12'h000;
    div_b = 12'h000;
    tick(4);
    rst_i <= 1'b0;
    tick(10);
    #1;
    chk_word({30'h0, mode}, {30'h0, CORE_FREE});
    chk_stat(st_a, 5'h07, 5'h1f);
    chk_word(fw, 32'h0000fff0);
    tick(1);
    mclk_cal_i <= 16'h0020;
    tick(5);
    #1;
    chk_word(fw, 32'h00010020);
    // exact 8 kHz on the first loop, 2 MHz (2.3 percent low) on the second
    tick(1);
    div_a <= 12'd2500;
    div_b <= 12'd10;
    tick(G2);
    #1;
    chk_stat(st_a, 5'h00, 5'h1f);
    chk_stat(st_b, 5'h13, 5'h1f);
    chk_word({30'h0, acc_b, acc_a}, 32'h2);
    chk_word({30'h0, mode}, {30'h0, CORE_NORMAL});
    chk_word(fw, 32'd1);
    tick(1);
    ref_sel_i <= 1'b1;
    tick(4);
    #1;
    chk_word(fw, 32'd250);
    n = 0;
    w0 = accu;
    repeat (1000) begin
      tick(1);
      #1;
      if (vld === 1'b1 && n == 0) w1 = ph;
      if (vld === 1'b1) n++;
    end
    chk_word(32'((n >= 19) && (n <= 21)), 32'h1);
    // a word every ten oscillator ticks; 200 ticks at the normal-mode rate of 250
    chk_word(ph - w1, 32'(10 * (n - 1)));
    chk_word(accu - w0, 32'd50000);
    tick(1);
    force_holdover_i <= 1'b1;
    tick(3);
    #1;
    chk_word({30'h0, mode}, {30'h0, CORE_HOLD});
    chk_word(fw, 32'd250);
    tick(1);
    force_holdover_i <= 1'b0;
    tick(3);
    #1;
    chk_word({30'h0, mode}, {30'h0, CORE_NORMAL});
    // about 1.538 MHz and 20 MHz, the latter near the widest limit
    tick(1);
    div_a <= 12'd13;
    div_b <= 12'd1;
    tick(G2);
    #1;
    chk_stat(st_a, 5'h08, 5'h1c);
    chk_stat(st_b, 5'h1b, 5'h1f);
    // loss on the feeding loop, second driven far out of range
    tick(1);
    ref_sel_i <= 1'b0;
    tick(4);
    div_a <= 12'd0;
    div_b <= 12'd9;
    #1;
    w0 = fw;
    tick(LOSS + 20);
    #1;
    chk_stat(st_a, 5'h07, 5'h07);
    chk_word({31'h0, acc_a}, 32'h1);
    chk_word({30'h0, mode}, {30'h0, CORE_HOLD});
    chk_word(fw, w0);
    tick(1);
    div_a <= 12'd2500;
    tick(G2);
    #1;
    chk_stat(st_a, 5'h00, 5'h1f);
    chk_stat(st_b, 5'h1f, 5'h1f);
    chk_word({30'h0, acc_b, acc_a}, 32'h2);
    chk_word({30'h0, mode}, {30'h0, CORE_NORMAL});
    report_and_stop();
  end
endmodule
